// ### logic/axis_cmd_pkg.sv
// Purpose: Constants and types for the stepper axis manual command block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Offsets, counts and the ctrl, limit and ferr reset values live here; param, home and mask reset to zero in the module.
package axis_cmd_pkg;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CMD = 12'h004;
  localparam logic [11:0] ADDR_PARAM = 12'h008;
  localparam logic [11:0] ADDR_HOME = 12'h00c;
  localparam logic [11:0] ADDR_LIMLO = 12'h010;
  localparam logic [11:0] ADDR_LIMHI = 12'h014;
  localparam logic [11:0] ADDR_POS = 12'h018;
  localparam logic [11:0] ADDR_STAT = 12'h01c;
  localparam logic [11:0] ADDR_IRQ = 12'h020;
  localparam logic [11:0] ADDR_MASK = 12'h024;
  localparam logic [11:0] ADDR_FERR = 12'h028;
  // Control register fields.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ENABLE = 2;
  localparam int CTRL_AUTO_BRAKE = 3;
  localparam int CTRL_AUTO_BOOST = 4;
  localparam int CTRL_JOG_POS = 5;
  localparam int CTRL_JOG_NEG = 6;
  localparam int CTRL_INC_ENC = 7;
  localparam int CTRL_HOME_EDGE = 8;
  // Command register bits, each a one-shot written as one.
  localparam int CMD_INC_POS = 0;
  localparam int CMD_INC_NEG = 1;
  localparam int CMD_HOME = 2;
  localparam int CMD_FORCE_REF = 3;
  localparam int CMD_BRAKE_ON = 4;
  localparam int CMD_BRAKE_OFF = 5;
  localparam int CMD_BOOST_ON = 6;
  localparam int CMD_BOOST_OFF = 7;
  localparam int CMD_PAUSE = 8;
  localparam int CMD_SYNC = 9;
  localparam int CMD_ACK = 10;
  localparam int CMD_STOP = 11;
  // Interrupt status bits.
  localparam int IRQ_REFUSED = 0;
  localparam int IRQ_HW = 1;
  localparam int IRQ_APP = 2;
  localparam int IRQ_DONE = 3;
  localparam int IRQ_SYNC = 4;
  localparam int IRQ_HOMED = 5;
  localparam int IRQ_W = 6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] FERR_RESET = 32'h0000_0400;
  localparam logic [31:0] LIMLO_RESET = 32'h8000_0000;
  localparam logic [31:0] LIMHI_RESET = 32'h7fff_ffff;
  localparam int STEP_PERIOD_NS = 10000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int STEP_CYCLES = STEP_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_MAN = 2'h1,
    MODE_AUTO = 2'h2,
    MODE_DIR = 2'h3
  } mode_e;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_JOG = 5'h02,
    ST_TARGET = 5'h04,
    ST_HOME = 5'h08,
    ST_PAUSED = 5'h10
  } motion_e;

  typedef struct packed {
    logic step;
    logic dir;
    logic enable;
    logic brake;
    logic boost;
  } drive_s;

  typedef struct packed {
    logic drive_fault;
    logic encoder_fault;
    logic output_fault;
  } hw_in_s;
endpackage

// ### logic/stepper_axis_manual_command.sv
// Purpose: One stepper axis channel: manual, direct and off modes with fault flags.
// Assumes: APB slave, zero wait states; external inputs are asynchronous.
// Notes: Motion is a step pulse generator at a fixed rate, toward a target, toward the home cam or in the jog direction.
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module stepper_axis_manual_command
  import axis_cmd_pkg::*;
#(
  parameter int STEP_DIV = STEP_CYCLES
) (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic HOME_CAM_I,
  input wire logic DRIVE_FAULT_I,
  input wire logic ENCODER_FAULT_I,
  input wire logic OUTPUT_FAULT_I,
  input wire logic AUTO_BRAKE_I,
  input wire logic AUTO_BOOST_I,
  output logic STEP_O,
  output logic DIR_O,
  output logic ENABLE_O,
  output logic BRAKE_O,
  output logic BOOST_O,
  output logic EVENT_O,
  output logic IRQ_O
);
  logic [31:0] ctrl, param, home_val, lim_lo, lim_hi, ferr_max, pos, target;
  logic [IRQ_W-1:0] irq_stat, irq_mask, irq_set;
  logic hw_fault, app_fault;
  logic [2:0] sync_home, sync_drv, sync_enc, sync_out, sync_abr, sync_abo;
  hw_in_s hw_in;
  logic cam, abr, abo, abr_d, abo_d;
  motion_e state;
  logic paused_req;
  logic [31:0] div_cnt;
  logic step_tick;
  drive_s drv;
  mode_e mode;
  logic wr, rd, cmd_wr, refuse;
  logic [31:0] cmd;
  logic [31:0] follow_err;

  function automatic logic agree(input logic [2:0] s);
    return s[1] == s[2];
  endfunction

  assign mode = mode_e'(ctrl[CTRL_MODE_LSB +: 2]);
  assign wr = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd = PSEL_I && !PENABLE_I && !PWRITE_I;
  assign cmd_wr = wr && (PADDR_I == ADDR_CMD);
  assign cmd = cmd_wr ? PWDATA_I : 32'h0000_0000;

  // Three-stage synchronisers; a level counts once stages two and three agree.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      sync_home <= 3'h0;
      sync_drv <= 3'h0;
      sync_enc <= 3'h0;
      sync_out <= 3'h0;
      sync_abr <= 3'h0;
      sync_abo <= 3'h0;
    end else begin
      sync_home <= {sync_home[1:0], HOME_CAM_I};
      sync_drv <= {sync_drv[1:0], DRIVE_FAULT_I};
      sync_enc <= {sync_enc[1:0], ENCODER_FAULT_I};
      sync_out <= {sync_out[1:0], OUTPUT_FAULT_I};
      sync_abr <= {sync_abr[1:0], AUTO_BRAKE_I};
      sync_abo <= {sync_abo[1:0], AUTO_BOOST_I};
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      cam <= 1'b0;
      hw_in <= '0;
      abr <= 1'b0;
      abo <= 1'b0;
    end else begin
      if (agree(sync_home)) cam <= sync_home[2];
      if (agree(sync_drv)) hw_in.drive_fault <= sync_drv[2];
      if (agree(sync_enc)) hw_in.encoder_fault <= sync_enc[2];
      if (agree(sync_out)) hw_in.output_fault <= sync_out[2];
      if (agree(sync_abr)) abr <= sync_abr[2];
      if (agree(sync_abo)) abo <= sync_abo[2];
    end
  end

  // Configuration registers.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl <= CTRL_RESET;
      param <= 32'h0000_0000;
      home_val <= 32'h0000_0000;
      lim_lo <= LIMLO_RESET;
      lim_hi <= LIMHI_RESET;
      ferr_max <= FERR_RESET;
      irq_mask <= '0;
    end else if (wr) begin
      if (PADDR_I == ADDR_CTRL) begin
        ctrl <= PWDATA_I;
      end else if (PADDR_I == ADDR_PARAM) begin
        param <= PWDATA_I;
      end else if (PADDR_I == ADDR_HOME) begin
        home_val <= PWDATA_I;
      end else if (PADDR_I == ADDR_LIMLO) begin
        lim_lo <= PWDATA_I;
      end else if (PADDR_I == ADDR_LIMHI) begin
        lim_hi <= PWDATA_I;
      end else if (PADDR_I == ADDR_FERR) begin
        ferr_max <= PWDATA_I;
      end else if (PADDR_I == ADDR_MASK) begin
        irq_mask <= PWDATA_I[IRQ_W-1:0];
      end
    end
  end

  // APB read data is registered in the setup cycle, so no wait states are needed.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      PRDATA_O <= 32'h0000_0000;
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O <= PSEL_I && !PENABLE_I;
      PSLVERR_O <= PSEL_I && !PENABLE_I && (PADDR_I > ADDR_FERR || PADDR_I[1:0] != 2'h0);
      if (rd) begin
        if (PADDR_I == ADDR_CTRL) begin
          PRDATA_O <= ctrl;
        end else if (PADDR_I == ADDR_PARAM) begin
          PRDATA_O <= param;
        end else if (PADDR_I == ADDR_HOME) begin
          PRDATA_O <= home_val;
        end else if (PADDR_I == ADDR_LIMLO) begin
          PRDATA_O <= lim_lo;
        end else if (PADDR_I == ADDR_LIMHI) begin
          PRDATA_O <= lim_hi;
        end else if (PADDR_I == ADDR_POS) begin
          PRDATA_O <= pos;
        end else if (PADDR_I == ADDR_STAT) begin
          PRDATA_O <= {23'h0, state == ST_IDLE, paused_req, app_fault, hw_fault, state};
        end else if (PADDR_I == ADDR_IRQ) begin
          PRDATA_O <= {{(32-IRQ_W){1'b0}}, irq_stat};
        end else if (PADDR_I == ADDR_MASK) begin
          PRDATA_O <= {{(32-IRQ_W){1'b0}}, irq_mask};
        end else if (PADDR_I == ADDR_FERR) begin
          PRDATA_O <= ferr_max;
        end else begin
          PRDATA_O <= 32'h0000_0000;
        end
      end
    end
  end

  // Step rate divider.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      div_cnt <= 32'h0;
      step_tick <= 1'b0;
    end else begin
      step_tick <= (div_cnt == 32'(STEP_DIV - 1));
      div_cnt <= (div_cnt == 32'(STEP_DIV - 1)) ? 32'h0 : div_cnt + 32'h1;
    end
  end

  // Refusal: motion only in manual mode, except the direct setpoint in direct mode.
  always_comb begin
    refuse = 1'b0;
    if (cmd_wr) begin
      if ((cmd[CMD_INC_POS] || cmd[CMD_INC_NEG] || cmd[CMD_HOME] || cmd[CMD_FORCE_REF])
          && (mode != MODE_MAN || state != ST_IDLE || hw_fault)) begin
        refuse = 1'b1;
      end
      if (cmd[CMD_FORCE_REF] && !ctrl[CTRL_INC_ENC]) begin
        refuse = 1'b1;
      end
    end
  end

  assign follow_err = (target > pos) ? target - pos : pos - target;

  // Motion sequencer.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      state <= ST_IDLE;
      pos <= 32'h0;
      target <= 32'h0;
      paused_req <= 1'b0;
      drv.step <= 1'b0;
      drv.dir <= 1'b0;
    end else begin
      drv.step <= 1'b0;
      if (cmd[CMD_PAUSE]) paused_req <= 1'b1;
      case (state)
        ST_IDLE: begin
          if (mode == MODE_MAN && !hw_fault) begin
            // Jog ignores soft limits so the axis can be driven back after ack.
            if (ctrl[CTRL_JOG_POS] ^ ctrl[CTRL_JOG_NEG]) begin
              state <= ST_JOG;
              drv.dir <= ctrl[CTRL_JOG_POS];
            end else if (!refuse && cmd[CMD_INC_POS]) begin
              target <= pos + param;
              drv.dir <= 1'b1;
              state <= ST_TARGET;
            end else if (!refuse && cmd[CMD_INC_NEG]) begin
              target <= pos - param;
              drv.dir <= 1'b0;
              state <= ST_TARGET;
            end else if (!refuse && cmd[CMD_HOME]) begin
              drv.dir <= ctrl[CTRL_HOME_EDGE];
              state <= ST_HOME;
            end else if (!refuse && cmd[CMD_FORCE_REF]) begin
              pos <= param;
              target <= param;
            end
          end else if (mode == MODE_DIR && !hw_fault && param != pos) begin
            target <= param;
            drv.dir <= $signed(param) > $signed(pos);
            state <= ST_TARGET;
          end
        end
        ST_JOG: begin
          if (!(ctrl[CTRL_JOG_POS] ^ ctrl[CTRL_JOG_NEG]) || mode != MODE_MAN || hw_fault
              || cmd[CMD_STOP]) begin
            state <= ST_IDLE;
          end else if (step_tick) begin
            drv.step <= 1'b1;
            pos <= drv.dir ? pos + 32'h1 : pos - 32'h1;
          end
        end
        ST_TARGET: begin
          if (pos == target || hw_fault || cmd[CMD_STOP] || mode == MODE_OFF) begin
            state <= (paused_req && pos == target) ? ST_PAUSED : ST_IDLE;
          end else if (step_tick) begin
            drv.step <= 1'b1;
            pos <= drv.dir ? pos + 32'h1 : pos - 32'h1;
          end
        end
        ST_HOME: begin
          if (cam) begin
            pos <= home_val;
            target <= home_val;
            state <= paused_req ? ST_PAUSED : ST_IDLE;
          end else if (hw_fault || cmd[CMD_STOP] || mode != MODE_MAN) begin
            state <= ST_IDLE;
          end else if (step_tick) begin
            drv.step <= 1'b1;
            pos <= drv.dir ? pos + 32'h1 : pos - 32'h1;
          end
        end
        ST_PAUSED: begin
          // A pause written in this very cycle stays pending for the next move.
          paused_req <= cmd[CMD_PAUSE];
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Fault flags; acknowledge only drops a flag whose cause is gone, but in off mode it always drops app_fault.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      hw_fault <= 1'b0;
      app_fault <= 1'b0;
    end else if (mode == MODE_OFF) begin
      app_fault <= app_fault && !(cmd[CMD_ACK]);
      hw_fault <= (hw_in != '0) || (hw_fault && !cmd[CMD_ACK]);
    end else begin
      hw_fault <= (hw_in != '0) || (hw_fault && !cmd[CMD_ACK]);
      // Soft limits are supervised in every state except jog, so never while jogging.
      app_fault <= (state != ST_JOG && ($signed(pos) > $signed(lim_hi)
                    || $signed(pos) < $signed(lim_lo)))
                   || (state == ST_TARGET && follow_err > ferr_max && mode == MODE_DIR)
                   || (app_fault && !cmd[CMD_ACK]);
    end
  end

  // Brake and boost take whichever edge, manual or automatic, came last.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      drv.brake <= 1'b0;
      drv.boost <= 1'b0;
      abr_d <= 1'b0;
      abo_d <= 1'b0;
    end else begin
      abr_d <= abr;
      abo_d <= abo;
      if (cmd[CMD_BRAKE_ON]) drv.brake <= 1'b1;
      else if (cmd[CMD_BRAKE_OFF]) drv.brake <= 1'b0;
      else if (ctrl[CTRL_AUTO_BRAKE] && abr != abr_d) drv.brake <= abr;
      if (cmd[CMD_BOOST_ON]) drv.boost <= 1'b1;
      else if (cmd[CMD_BOOST_OFF]) drv.boost <= 1'b0;
      else if (ctrl[CTRL_AUTO_BOOST] && abo != abo_d) drv.boost <= abo;
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      drv.enable <= 1'b0;
    end else begin
      drv.enable <= ctrl[CTRL_ENABLE];
    end
  end

  // Interrupt status: set wins over a write-one clear in the same cycle.
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_REFUSED] = refuse;
    irq_set[IRQ_HW] = hw_in != '0;
    irq_set[IRQ_APP] = app_fault;
    irq_set[IRQ_DONE] = (state == ST_TARGET) && (pos == target);
    irq_set[IRQ_SYNC] = cmd[CMD_SYNC];
    irq_set[IRQ_HOMED] = (state == ST_HOME) && cam;
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= irq_set | (irq_stat & ~((wr && PADDR_I == ADDR_IRQ) ?
                                        PWDATA_I[IRQ_W-1:0] : '0));
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      STEP_O <= 1'b0;
      DIR_O <= 1'b0;
      ENABLE_O <= 1'b0;
      BRAKE_O <= 1'b0;
      BOOST_O <= 1'b0;
      EVENT_O <= 1'b0;
      IRQ_O <= 1'b0;
    end else begin
      STEP_O <= drv.step;
      DIR_O <= drv.dir;
      ENABLE_O <= drv.enable;
      BRAKE_O <= drv.brake;
      BOOST_O <= drv.boost;
      EVENT_O <= cmd[CMD_SYNC];
      IRQ_O <= |(irq_stat & irq_mask);
    end
  end
endmodule
`default_nettype wire

// ### tb/axis_drive_model.sv
// Purpose: Translator drive model that counts steps and closes a home cam.
// Assumes: One step per STEP_O pulse; DIR_O high means the positive direction.
// Notes: The cam closes three steps after arming, so homing works in either direction.
`timescale 1ns/1ps
`default_nettype none
module axis_drive_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic step_i,
  input wire logic dir_i,
  input wire logic arm_i,
  output logic cam_o,
  output logic signed [31:0] count_o
);
  logic [7:0] moved;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      count_o <= 32'sh0;
    else if (step_i)
      count_o <= dir_i ? count_o + 32'sh1 : count_o - 32'sh1;
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i || !arm_i)
      moved <= 8'h00;
    else if (step_i && moved != 8'hff)
      moved <= moved + 8'h01;
  end
  assign cam_o = arm_i && (moved >= 8'h03);
endmodule
`default_nettype wire

// ### tb/axis_cmd_asserts.sv
// Purpose: Port-level assertions for the stepper axis command block.
// Assumes: Zero-wait APB slave; one step per STEP_DIV cycles.
// Notes: The step gap counter saturates, so a long idle never wraps it.
`timescale 1ns/1ps
`default_nettype none
module axis_cmd_asserts
  import axis_cmd_pkg::*;
#(
  parameter int STEP_DIV = STEP_CYCLES
) (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic STEP_O,
  input wire logic ENABLE_O,
  input wire logic BRAKE_O,
  input wire logic BOOST_O,
  input wire logic EVENT_O
);
  logic acc;
  logic cmd_wr;
  int gap;
  assign acc = PSEL_I && PENABLE_I;
  assign cmd_wr = acc && PWRITE_I && (PADDR_I == ADDR_CMD);
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I)
      gap <= 1000;
    else
      gap <= STEP_O ? 1 : ((gap < 1000) ? gap + 1 : gap);
  end
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RST_I);
  a_ready_access: assert property (acc |-> PREADY_O)
    else $error("pready missing in access phase");
  a_ready_only: assert property (PREADY_O |-> acc)
    else $error("pready outside access phase");
  a_err_unmapped: assert property (acc && PADDR_I > ADDR_FERR |-> PSLVERR_O)
    else $error("no slave error on unmapped address");
  a_err_zero: assert property (PSLVERR_O && !PWRITE_I |-> PRDATA_O == 32'h0)
    else $error("unmapped read data not zero");
  a_enable_follow: assert property (
    acc && PWRITE_I && PADDR_I == ADDR_CTRL |->
    ##3 ENABLE_O == $past(PWDATA_I[CTRL_ENABLE], 3))
    else $error("enable output does not follow control bit");
  a_sync_event: assert property (cmd_wr && PWDATA_I[CMD_SYNC] |=> EVENT_O)
    else $error("no event after sync command");
  a_event_single: assert property (EVENT_O |=> !EVENT_O)
    else $error("event pulse longer than one cycle");
  a_brake_on: assert property (
    cmd_wr && PWDATA_I[CMD_BRAKE_ON] && !PWDATA_I[CMD_BRAKE_OFF] |-> ##[1:2] BRAKE_O)
    else $error("brake not raised by manual command");
  a_boost_off: assert property (
    cmd_wr && PWDATA_I[CMD_BOOST_OFF] && !PWDATA_I[CMD_BOOST_ON] |-> ##[1:2] !BOOST_O)
    else $error("boost not dropped by manual command");
  a_step_gap: assert property (STEP_O |-> gap >= STEP_DIV)
    else $error("steps closer than the step period");
  c_inc: cover property (cmd_wr && PWDATA_I[CMD_INC_POS]);
  c_step: cover property (STEP_O);
  c_slverr: cover property (PSLVERR_O);
endmodule
bind stepper_axis_manual_command axis_cmd_asserts #(.STEP_DIV(STEP_DIV)) i_asserts (
  .MCLK_I(MCLK_I),
  .RST_I(RST_I),
  .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I),
  .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O),
  .STEP_O(STEP_O),
  .ENABLE_O(ENABLE_O),
  .BRAKE_O(BRAKE_O),
  .BOOST_O(BOOST_O),
  .EVENT_O(EVENT_O)
);
`default_nettype wire

// ### tb/tb_top.sv
// Purpose: Self-checking bench for the stepper axis command block.
// Assumes: Zero-wait APB; STEP_DIV of 4 keeps moves short.
// Notes: Positions are checked against the drive model's own step count.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import axis_cmd_pkg::*;
  typedef struct packed {logic [11:0] a; logic [31:0] v;} row_s;
  localparam row_s ROWS [10] = '{'{ADDR_CTRL, CTRL_RESET}, '{ADDR_CMD, 32'h0},
    '{ADDR_LIMLO, 32'h8000_0000}, '{ADDR_LIMHI, 32'h7fff_ffff}, '{ADDR_POS, 32'h0},
    '{ADDR_STAT, 32'h101}, '{ADDR_IRQ, 32'h0}, '{ADDR_MASK, 32'h0},
    '{ADDR_FERR, FERR_RESET}, '{12'h02c, 32'h0}};
  logic clk;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err, cam, step, dir, en, brk, bst, evt, irq;
  logic dflt = 1'b0;
  logic eflt = 1'b0;
  logic oflt = 1'b0;
  logic ab = 1'b0;
  logic abo = 1'b0;
  logic arm = 1'b0;
  logic signed [31:0] cnt;
  logic signed [31:0] c0;
  int bad_count = 0;
  int tests_run = 0;
  stepper_axis_manual_command #(.STEP_DIV(4)) i_stepper_axis_manual_command (
    .MCLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .HOME_CAM_I(cam), .DRIVE_FAULT_I(dflt),
    .ENCODER_FAULT_I(eflt), .OUTPUT_FAULT_I(oflt), .AUTO_BRAKE_I(ab),
    .AUTO_BOOST_I(abo), .STEP_O(step), .DIR_O(dir), .ENABLE_O(en), .BRAKE_O(brk),
    .BOOST_O(bst), .EVENT_O(evt), .IRQ_O(irq));
  axis_drive_model i_axis_drive_model (.clk_i(clk), .rst_i(rst), .step_i(step),
    .dir_i(dir), .arm_i(arm), .cam_o(cam), .count_o(cnt));
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Each transfer starts on a fresh edge so no strobe is assigned twice in one step.
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Only the watchdog ends a wait that never sees pready.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(string nm, logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(nm, rd, e);
  endtask
  task automatic wait_irq(int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_IRQ, 32'h0);
      n++;
    end while (rd[b] !== 1'b1 && n < 200);
    check("irq_bit", 32'(rd[b]), 32'h1);
  endtask
  task automatic auto_in(int i, logic v);
    @(posedge clk);
    if (i == 0)
      ab <= v;
    else
      abo <= v;
    repeat (8) @(posedge clk);
  endtask
  task automatic outchk(int i, logic e);
    repeat (2) @(posedge clk);
    check("drive_out", 32'(i ? bst : brk), 32'(e));
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    bad_count++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (ROWS[k]) begin
      rdchk("reset_value", ROWS[k].a, ROWS[k].v);
      check("slverr", 32'(err), 32'(ROWS[k].a > ADDR_FERR));
    end
    wr(ADDR_MASK, 32'h3f);
    wr(ADDR_CTRL, 32'h5);
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_IRQ, 32'h3f);
      wr(ADDR_PARAM, i ? 32'h5 : 32'h3);
      wr(ADDR_CMD, 32'h1 << (CMD_INC_POS + i));
      wait_irq(IRQ_DONE);
      rdchk("pos_inc", ADDR_POS, i ? 32'hffff_fffe : 32'h3);
      check("steps_inc", cnt, i ? 32'hffff_fffe : 32'h3);
      check("dir_inc", 32'(dir), i ? 32'h0 : 32'h1);
    end
    wr(ADDR_CTRL, 32'h6);
    wr(ADDR_IRQ, 32'h3f);
    wr(ADDR_CMD, 32'h1);
    rdchk("refused", ADDR_IRQ, 32'h1);
    check("irq_line", 32'(irq), 32'h1);
    rdchk("pos_kept", ADDR_POS, 32'hffff_fffe);
    wr(ADDR_MASK, 32'h0);
    repeat (3) @(posedge clk);
    check("irq_masked", 32'(irq), 32'h0);
    wr(ADDR_MASK, 32'h3f);
    wr(ADDR_IRQ, 32'h3f);
    wr(ADDR_CTRL, 32'h5);
    wr(ADDR_PARAM, 32'h64);
    wr(ADDR_CMD, 32'h8);
    rdchk("force_refused", ADDR_IRQ, 32'h1);
    wr(ADDR_CTRL, 32'h85);
    wr(ADDR_CMD, 32'h8);
    rdchk("pos_forced", ADDR_POS, 32'h64);
    check("no_move", cnt, 32'hffff_fffe);
    wr(ADDR_LIMHI, 32'h5a);
    wr(ADDR_CMD, 32'h400);
    rdchk("app_held", ADDR_STAT, 32'h141);
    wr(ADDR_CTRL, 32'hc5);
    repeat (120) @(posedge clk);
    wr(ADDR_CTRL, 32'h85);
    repeat (4) @(posedge clk);
    c0 = cnt;
    check("jog_moved", 32'(cnt < -12), 32'h1);
    rdchk("pos_jog", ADDR_POS, 32'h66 + cnt);
    repeat (20) @(posedge clk);
    check("jog_stopped", cnt, c0);
    wr(ADDR_CMD, 32'h400);
    rdchk("app_cleared", ADDR_STAT, 32'h101);
    for (int i = 0; i < 3; i++) begin
      {dflt, eflt, oflt} <= 3'h4 >> i;
      repeat (8) @(posedge clk);
      wr(ADDR_CMD, 32'h400);
      rdchk("hw_held", ADDR_STAT, 32'h121);
      {dflt, eflt, oflt} <= 3'h0;
      repeat (8) @(posedge clk);
      wr(ADDR_CMD, 32'h400);
      rdchk("hw_cleared", ADDR_STAT, 32'h101);
    end
    wr(ADDR_HOME, 32'h40);
    wr(ADDR_IRQ, 32'h3f);
    arm <= 1'b1;
    wr(ADDR_CMD, 32'h4);
    wait_irq(IRQ_HOMED);
    rdchk("pos_home", ADDR_POS, 32'h40);
    arm <= 1'b0;
    wr(ADDR_IRQ, 32'h3f);
    wr(ADDR_PARAM, 32'h8);
    wr(ADDR_CMD, 32'h1);
    wr(ADDR_CMD, 32'h100);
    rdchk("pause_pending", ADDR_STAT, 32'h84);
    wait_irq(IRQ_DONE);
    rdchk("pause_done", ADDR_STAT, 32'h101);
    wr(ADDR_IRQ, 32'h3f);
    wr(ADDR_CMD, 32'h200);
    rdchk("sync", ADDR_IRQ, 32'h10);
    wr(ADDR_CTRL, 32'h9d);
    for (int i = 0; i < 2; i++) begin
      auto_in(i, 1'b1);
      outchk(i, 1'b1);
      wr(ADDR_CMD, 32'h20 << (2 * i));
      outchk(i, 1'b0);
      wr(ADDR_CMD, 32'h10 << (2 * i));
      outchk(i, 1'b1);
      auto_in(i, 1'b0);
      outchk(i, 1'b0);
    end
    wr(ADDR_PARAM, 32'h4c);
    wr(ADDR_CTRL, 32'h7);
    repeat (40) @(posedge clk);
    rdchk("pos_direct", ADDR_POS, 32'h4c);
    check("dir_direct", 32'(dir), 32'h1);
    wr(ADDR_CTRL, 32'h4);
    c0 = cnt;
    wr(ADDR_PARAM, 32'h10);
    wr(ADDR_LIMHI, 32'h20);
    repeat (20) @(posedge clk);
    check("off_still", cnt, c0);
    rdchk("off_no_fault", ADDR_STAT, 32'h101);
    check("off_enable", 32'(en), 32'h1);
    wr(ADDR_CTRL, 32'h0);
    repeat (4) @(posedge clk);
    check("off_disable", 32'(en), 32'h0);
    wr(ADDR_CTRL, 32'h5);
    repeat (4) @(posedge clk);
    check("on_enable", 32'(en), 32'h1);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    check("rst_enable", 32'(en), 32'h0);
    rst <= 1'b0;
    rdchk("rst_ctrl", ADDR_CTRL, CTRL_RESET);
    rdchk("rst_pos", ADDR_POS, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
